// [sim/lsf_framer_asserts.sv]
// Concurrent checks on the framer ports
`timescale 1ns/1ps
module lsf_framer_asserts (
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_rst,
  // Watched inputs
  input wire logic       i_diag_wr,
  input wire logic [7:0] i_diag_data,
  input wire logic       i_rx_sync_lock,
  input wire logic [1:0] i_channel_quality_estimate,
  input wire logic       i_received_housekeeping_bit,
  input wire logic       i_half_cell_tick,
  input wire logic       i_line_output_disable_pin,
  // Watched outputs
  input wire logic       o_line_tx,
  input wire logic       o_line_bias,
  input wire logic [7:0] o_line_status_word
);
  // ****************************************
  // Port relations
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  chk_rsvd_reads_ones: assert property (o_line_status_word[6:4] == 3'h7)
    else $error("reserved status bits not ones");
  chk_rev_bit_fixed: assert property (o_line_status_word[7] == lsf_pkg::REV_ID)
    else $error("revision bit wrong");
  chk_quality_follows: assert property (!$past(i_rst) |->
    o_line_status_word[2:1] == $past(i_channel_quality_estimate))
    else $error("quality bits do not follow input");
  chk_received_housekeeping_bit_follows: assert property (!$past(i_rst) |->
    o_line_status_word[3] == $past(i_received_housekeeping_bit))
    else $error("housekeeping status bit wrong");
  chk_sync_lost_clears: assert property (!i_rx_sync_lock |=> !o_line_status_word[0])
    else $error("sync bit kept after lock lost");
  chk_diag_bias_line: assert property (i_diag_wr && i_diag_data[6] &&
    i_diag_data[7:4] != 4'hf |-> ##2 o_line_bias)
    else $error("diagnostics disable did not bias line");
  chk_pin_bias_line: assert property (i_line_output_disable_pin [*6] |-> o_line_bias)
    else $error("disable pin did not bias line");
  chk_bias_quiet_line: assert property (o_line_bias |-> !o_line_tx)
    else $error("line driven while biased");
  chk_level_on_tick: assert property (!o_line_bias && !$past(o_line_bias) &&
    $changed(o_line_tx) |-> $past(i_half_cell_tick))
    else $error("line level moved off half cell");
  cover property ($rose(o_line_bias));
  cover property ($fell(o_line_status_word[0]));
  cover property (!o_line_bias && $changed(o_line_tx));
endmodule

// [sim/lsf_remote_model.sv]
// Far-end line receiver: paces half cells and judges the line code
`timescale 1ns/1ps
module lsf_remote_model (
  // Clock and control
  input  wire logic i_clk,
  input  wire logic i_run,
  input  wire logic i_clr,
  // Line
  input  wire logic i_line_tx,
  output logic      o_half_tick,
  // Counts
  output int        o_halves,
  output int        o_eq_even,
  output int        o_eq_odd,
  output int        o_edges
);
  logic [2:0] div = 3'h0;
  logic       last = 1'b0;
  logic       prev = 1'b0;
  logic       ph = 1'b0;
  initial o_half_tick = 1'b0;
  // Half cell every eight clocks, stands still when stalled
  always @(posedge i_clk) begin
    div <= i_run ? div + 3'h1 : 3'h0;
    o_half_tick <= i_run && div == 3'h7;
  end
  // Equal halves may only fall across cell edges in one phase
  always @(posedge i_clk) begin
    prev <= i_line_tx;
    if (i_clr) begin
      o_halves <= 0;
      o_eq_even <= 0;
      o_eq_odd <= 0;
      o_edges <= 0;
    end else begin
      if (i_line_tx != prev) o_edges <= o_edges + 1;
      if (o_half_tick) begin
        last <= i_line_tx;
        ph <= ~ph;
        o_halves <= o_halves + 1;
        if (i_line_tx == last && ph) o_eq_odd <= o_eq_odd + 1;
        if (i_line_tx == last && !ph) o_eq_even <= o_eq_even + 1;
      end
    end
  end
endmodule

// [sim/subscriber_line_framer_status_tb.sv]
// Self-checking bench of the line framer
`timescale 1ns/1ps
module subscriber_line_framer_status_tb;
  logic                i_clk = 1'b0;
  logic                i_rst = 1'b1;
  logic                cw = 1'b0, dw = 1'b0, fp = 1'b0, lock = 1'b0, rhk = 1'b0;
  logic                tv = 1'b0, pin = 1'b0, run = 1'b0, clr = 1'b0, acc;
  logic                bck = 1'b0, stb = 1'b0, sdi = 1'b0, sdo, lpb, mst;
  logic [7:0]          cd = 8'h00, dd = 8'h00, sw, sb, eb;
  logic [1:0]          q = 2'h0;
  lsf_pkg::lsf_frame_t fr = '0;
  logic                tr, ltx, lb, ht;
  int                  halves, eq0, eq1, edges, n, nq = 0;
  int                  mismatches = 0, samples_checked = 0, cyc = 0;
  always #50 i_clk = ~i_clk;
  // ****************************************
  // Design, far end and helpers
  // ****************************************
  lsf_framer u_lsf_framer (.i_clk(i_clk), .i_rst(i_rst), .i_ctrl_wr(cw),
    .i_ctrl_data(cd), .i_diag_wr(dw), .i_diag_data(dd), .i_frame_pulse(fp),
    .i_rx_sync_lock(lock), .i_channel_quality_estimate(q),
    .i_received_housekeeping_bit(rhk), .i_tx_valid(tv), .o_tx_ready(tr),
    .i_tx_frame(fr), .i_bit_clk(bck), .i_channel_boundary_strobe(stb),
    .i_system_stream_input(sdi), .o_system_stream_output(sdo),
    .i_half_cell_tick(ht), .i_line_output_disable_pin(pin), .o_line_tx(ltx),
    .o_line_bias(lb), .o_line_loopback(lpb), .o_line_status_word(sw), .o_master_role(mst));
  lsf_remote_model u_lsf_remote_model (.i_clk(i_clk), .i_run(run), .i_clr(clr),
    .i_line_tx(ltx), .o_half_tick(ht), .o_halves(halves), .o_eq_even(eq0),
    .o_eq_odd(eq1), .o_edges(edges));
  // Status word expected from receiver inputs in framed mode
  function automatic logic [7:0] exp_st(logic l, logic [1:0] c, logic h);
    return {lsf_pkg::REV_ID, lsf_pkg::STAT_RSVD, h, c, l};
  endfunction
  task automatic step(int k = 1);
    repeat (k) @(posedge i_clk);
    #10;
  endtask
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Control write when ctl is set, diagnostics write otherwise
  task automatic wr(logic ctl, logic [7:0] d);
    cw = ctl;
    dw = ~ctl;
    cd = d;
    dd = d;
    step();
    cw = 1'b0;
    dw = 1'b0;
  endtask
  task automatic pulse();
    fp = 1'b1;
    step();
    fp = 1'b0;
    step(2);
  endtask
  // Modem port pin pulse: strobe when s is set, bit clock otherwise
  task automatic mpulse(logic s);
    if (s) begin
      stb = 1'b1;
    end else begin
      bck = 1'b1;
    end
    step(4);
    stb = 1'b0;
    bck = 1'b0;
    step(4);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(85170));
    step(12);
    i_rst = 1'b0;
    step();
    chk(sw, exp_st(1'b0, 2'h0, 1'b0));
    for (int k = 0; k < 40; k++) begin
      {lock, q, rhk} = 4'($urandom);
      step(2);
      chk(sw, exp_st(lock, q, rhk));
    end
    lock = 1'b1;
    wr(1'b1, 8'h24);
    step(2);
    chk({7'h0, sw[0]}, 8'h00);
    chk({7'h0, tr}, 8'h00);
    // Keep diagnostics; no loopback selected in any mode
    wr(1'b1, 8'h04);
    wr(1'b0, 8'h00);
    step(3);
    chk({7'h0, lb}, 8'h00);
    pin = 1'b1;
    step(6);
    chk({7'h0, lb}, 8'h01);
    pin = 1'b0;
    step(6);
    chk({7'h0, lb}, 8'h00);
    wr(1'b0, 8'h40);
    step();
    chk({7'h0, lb}, 8'h01);
    chk({7'h0, ltx}, 8'h00);
    pulse();
    chk({7'h0, lb}, 8'h01);
    wr(1'b1, 8'h00);
    pulse();
    chk({7'h0, lb}, 8'h00);
    wr(1'b1, 8'h04);
    wr(1'b0, 8'hf4);
    step(2);
    chk({7'h0, lb}, 8'h00);
    wr(1'b0, 8'h00);
    // Line stalled: buffer takes two frames then refuses
    tv = 1'b1;
    fr = 19'($urandom);
    for (int k = 0; k < 4; k++) begin
      chk({7'h0, tr}, {7'h0, nq < 2});
      if (tr) nq++;
      step();
      if (nq < 2) fr = 19'($urandom);
    end
    tv = 1'b0;
    run = 1'b1;
    n = 0;
    while (tr !== 1'b1 && n < 3000) begin
      step();
      n++;
    end
    chk({7'h0, tr}, 8'h01);
    // Live traffic judged by the far end
    tv = 1'b1;
    clr = 1'b1;
    step();
    clr = 1'b0;
    for (int k = 0; k < 800; k++) begin
      acc = tr;
      step();
      if (acc) fr = 19'($urandom);
    end
    chk({7'h0, eq0 == 0 || eq1 == 0}, 8'h01);
    chk({7'h0, halves > 40}, 8'h01);
    // Modem port: status word out MSB first, one byte in
    tv = 1'b0;
    wr(1'b1, 8'h24);
    eb = exp_st(1'b0, q, rhk);
    sb = 8'($urandom) | 8'h01;
    mpulse(1'b1);
    chk({7'h0, sdo}, {7'h0, eb[7]});
    for (int k = 6; k >= 0; k--) begin
      sdi = sb[k+1];
      mpulse(1'b0);
      chk({7'h0, sdo}, {7'h0, eb[k]});
    end
    sdi = sb[0];
    mpulse(1'b0);
    mpulse(1'b1);
    chk({7'h0, tr}, 8'h00);
    // Framed master may use the line loopback
    wr(1'b1, 8'h44);
    wr(1'b0, 8'h04);
    step();
    chk({6'h0, mst, lpb}, 8'h03);
    wr(1'b0, 8'h00);
    pin = 1'b1;
    step(8);
    clr = 1'b1;
    step();
    clr = 1'b0;
    step(200);
    chk({7'h0, edges == 0 && halves > 0}, 8'h01);
    summarize();
  end
endmodule
bind lsf_framer lsf_framer_asserts u_lsf_framer_asserts (.i_clk(i_clk), .i_rst(i_rst),
  .i_diag_wr(i_diag_wr), .i_diag_data(i_diag_data), .i_rx_sync_lock(i_rx_sync_lock),
  .i_channel_quality_estimate(i_channel_quality_estimate),
  .i_received_housekeeping_bit(i_received_housekeeping_bit),
  .i_half_cell_tick(i_half_cell_tick),
  .i_line_output_disable_pin(i_line_output_disable_pin), .o_line_tx(o_line_tx),
  .o_line_bias(o_line_bias), .o_line_status_word(o_line_status_word));

// [src/lsf_fifo2.sv]
// Two-entry valid/ready buffer
`timescale 1ns/1ps
module lsf_fifo2 #(
  parameter int W = 19
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Fill side
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  // Drain side
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);

  logic [W-1:0] mem_ff [2];
  logic [W-1:0] nxt_mem [2];
  logic         wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [1:0]   cnt_ff, nxt_cnt;
  logic         push, pop;

  // Handshakes from the fill level
  assign o_in_ready  = (cnt_ff != 2'h2);
  assign o_out_valid = (cnt_ff != 2'h0);
  assign o_out_data  = mem_ff[rp_ff];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // Pointer and storage update
  always_comb begin
    nxt_mem = mem_ff;
    nxt_wp  = wp_ff;
    nxt_rp  = rp_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_mem[wp_ff] = i_in_data;
      nxt_wp         = ~wp_ff;
    end
    if (pop) begin
      nxt_rp = ~rp_ff;
    end
    if (push & ~pop) begin
      nxt_cnt = cnt_ff + 2'h1;
    end else if (pop & ~push) begin
      nxt_cnt = cnt_ff - 2'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
      wp_ff     <= 1'h0;
      rp_ff     <= 1'h0;
      cnt_ff    <= 2'h0;
    end else begin
      mem_ff <= nxt_mem;
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

// [src/lsf_framer.sv]
// Line framer, status word and modem port of the subscriber transceiver
`timescale 1ns/1ps
module lsf_framer (
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  // Register writes carried by the C-channel
  input  wire logic                i_ctrl_wr,
  input  wire logic [7:0]          i_ctrl_data,
  input  wire logic                i_diag_wr,
  input  wire logic [7:0]          i_diag_data,
  input  wire logic                i_frame_pulse,
  // Receiver state
  input  wire logic                i_rx_sync_lock,
  input  wire logic [1:0]          i_channel_quality_estimate,
  input  wire logic                i_received_housekeeping_bit,
  // Framed transmit data
  input  wire logic                i_tx_valid,
  output logic                     o_tx_ready,
  input  wire lsf_pkg::lsf_frame_t i_tx_frame,
  // Modem-mode serial port pins
  input  wire logic                i_bit_clk,
  input  wire logic                i_channel_boundary_strobe,
  input  wire logic                i_system_stream_input,
  output logic                     o_system_stream_output,
  // Line side
  input  wire logic                i_half_cell_tick,
  input  wire logic                i_line_output_disable_pin,
  output logic                     o_line_tx,
  output logic                     o_line_bias,
  output logic                     o_line_loopback,
  // Status and role
  output logic [7:0]               o_line_status_word,
  output logic                     o_master_role
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int NPIN = 4;
  localparam int P_DIS = 0;
  localparam int P_BCK = 1;
  localparam int P_STB = 2;
  localparam int P_DAT = 3;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_ff, s2_ff, s3_ff;
  logic [NPIN-1:0] flt_ff, nxt_flt;

  assign pin_raw = {i_system_stream_input, i_channel_boundary_strobe,
                    i_bit_clk, i_line_output_disable_pin};

  // Filtered level follows once stages two and three agree
  always_comb begin
    nxt_flt = (s2_ff & s3_ff) | (flt_ff & (s2_ff | s3_ff));
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      flt_ff <= '0;
    end else begin
      s1_ff  <= pin_raw;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      flt_ff <= nxt_flt;
    end
  end

  // ****************************************
  // Control and diagnostics registers
  // ****************************************
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] diag_ff, nxt_diag;

  // A diagnostics write in the frame-pulse cycle wins over the clear
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_diag = diag_ff;
    if (i_ctrl_wr) begin
      nxt_ctrl = i_ctrl_data;
    end
    if (i_diag_wr) begin
      nxt_diag = i_diag_data;
    end else if (i_frame_pulse && !ctrl_ff[lsf_pkg::CTRL_DIAG_KEEP]) begin
      nxt_diag = lsf_pkg::DIAG_RST;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_ff <= lsf_pkg::CTRL_RST;
      diag_ff <= lsf_pkg::DIAG_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
      diag_ff <= nxt_diag;
    end
  end

  // ****************************************
  // Effective configuration
  // ****************************************
  lsf_pkg::lsf_cfg_t cfg;
  logic              dflt;

  assign dflt = (diag_ff[lsf_pkg::DIAG_DEF_HI:lsf_pkg::DIAG_DEF_LO] == lsf_pkg::DIAG_DEF_KEY);

  // Default modes force framed operation with features off
  always_comb begin
    cfg.modem   = ctrl_ff[lsf_pkg::CTRL_MODEM];
    cfg.rate160 = ctrl_ff[lsf_pkg::CTRL_RATE160];
    cfg.dchan_in_bchan_select    = ctrl_ff[lsf_pkg::CTRL_DCHAN_IN_BCHAN_SELECT];
    cfg.hk      = ctrl_ff[lsf_pkg::CTRL_HK];
    cfg.line_output_disable_bit     = diag_ff[lsf_pkg::DIAG_DLO];
    cfg.loop    = diag_ff[lsf_pkg::DIAG_LOOP_HI:lsf_pkg::DIAG_LOOP_LO];
    if (dflt) begin
      cfg.modem   = 1'h0;
      cfg.rate160 = diag_ff[lsf_pkg::DIAG_DEF_SEL];
      cfg.dchan_in_bchan_select    = 1'h0;
      cfg.hk      = 1'h0;
      cfg.line_output_disable_bit     = 1'h0;
      cfg.loop    = 2'h0;
    end
  end

  assign o_master_role   = ctrl_ff[lsf_pkg::CTRL_MASTER];
  // Analog loop enable; set from the loop field, in either role and in modem or framed mode; default modes force it off
  assign o_line_loopback = (cfg.loop == lsf_pkg::LOOP_LINE);

  // ****************************************
  // Status word
  // ****************************************
  logic [7:0] stat_ff, nxt_stat;

  // Sync bit follows lock outside modem mode, held low in modem mode; it drops the cycle after lock goes
  always_comb begin
    nxt_stat = {lsf_pkg::REV_ID,
                lsf_pkg::STAT_RSVD,
                i_received_housekeeping_bit,
                i_channel_quality_estimate,
                i_rx_sync_lock & ~cfg.modem};
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stat_ff <= {lsf_pkg::REV_ID, lsf_pkg::STAT_RSVD, 4'h0};
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  assign o_line_status_word = stat_ff;

  // ****************************************
  // Modem-mode serial port
  // ****************************************
  logic       bck_prev_ff, stb_prev_ff;
  logic [7:0] rx_sr_ff, nxt_rx_sr;
  logic [7:0] tx_sr_ff, nxt_tx_sr;
  logic       out_ff, nxt_out;
  logic       bck_rise, stb_rise, mdm_push;

  assign bck_rise = flt_ff[P_BCK] & ~bck_prev_ff;
  assign stb_rise = flt_ff[P_STB] & ~stb_prev_ff;
  assign mdm_push = stb_rise & cfg.modem;

  // Shift C-channel bits MSB first; the strobe closes a channel
  always_comb begin
    nxt_rx_sr = rx_sr_ff;
    nxt_tx_sr = tx_sr_ff;
    nxt_out   = out_ff;
    if (stb_rise) begin
      nxt_tx_sr = stat_ff;
    end else if (bck_rise) begin
      nxt_rx_sr = {rx_sr_ff[6:0], flt_ff[P_DAT]};
      nxt_tx_sr = {tx_sr_ff[6:0], 1'h0};
    end
    if (cfg.loop == lsf_pkg::LOOP_STREAM) begin
      nxt_out = flt_ff[P_DAT];
    end else begin
      nxt_out = tx_sr_ff[7];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bck_prev_ff <= 1'h0;
      stb_prev_ff <= 1'h0;
      rx_sr_ff    <= 8'h00;
      tx_sr_ff    <= 8'h00;
      out_ff      <= 1'h0;
    end else begin
      bck_prev_ff <= flt_ff[P_BCK];
      stb_prev_ff <= flt_ff[P_STB];
      rx_sr_ff    <= nxt_rx_sr;
      tx_sr_ff    <= nxt_tx_sr;
      out_ff      <= nxt_out;
    end
  end

  assign o_system_stream_output = out_ff;

  // ****************************************
  // Transmit buffer
  // ****************************************
  lsf_pkg::lsf_frame_t buf_in, buf_out;
  logic                buf_in_valid, buf_in_ready, buf_out_valid, buf_pop;

  // Modem bytes ride in B1; other fields idle
  always_comb begin
    buf_in       = lsf_pkg::IDLE_FRAME;
    buf_in_valid = i_tx_valid;
    if (cfg.modem) begin
      buf_in.b1    = rx_sr_ff;
      buf_in_valid = mdm_push;
    end else begin
      buf_in = i_tx_frame;
    end
  end

  assign o_tx_ready = buf_in_ready & ~cfg.modem;

  lsf_fifo2 #(
    .W($bits(lsf_pkg::lsf_frame_t))
  ) u_buf (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_in_valid  (buf_in_valid),
    .o_in_ready  (buf_in_ready),
    .i_in_data   (buf_in),
    .o_out_valid (buf_out_valid),
    .i_out_ready (buf_pop),
    .o_out_data  (buf_out)
  );

  // ****************************************
  // Frame serialiser
  // ****************************************
  lsf_pkg::lsf_frame_t cur_ff, nxt_cur;
  logic [4:0]          idx_ff, nxt_idx;
  logic [7:0]          pat_ff, nxt_pat;
  logic [4:0]          len;
  logic [19:0]         fbits;
  logic [7:0]          b1slot;
  logic [1:0]          dslot;
  logic                take, last, enc_bit;

  // Frame layout, bit 0 first on the line
  always_comb begin
    b1slot = cur_ff.b1;
    dslot  = cur_ff.dch;
    if (cfg.dchan_in_bchan_select) begin
      b1slot = {lsf_pkg::D_PAD, cur_ff.dch};
      dslot  = 2'h3;
    end
    fbits = 20'hfffff;
    if (cfg.modem) begin
      len         = lsf_pkg::LEN_MODEM;
      fbits[7:0]  = cur_ff.b1;
    end else if (cfg.rate160) begin
      len         = lsf_pkg::LEN_160;
      fbits       = {cur_ff.b2, b1slot, dslot, cfg.hk, pat_ff[0]};
    end else begin
      len         = lsf_pkg::LEN_80;
      fbits[9:0]  = {b1slot, dslot[0], pat_ff[0]};
    end
  end

  assign last    = (idx_ff >= (len - 5'h01));
  assign buf_pop = take & last;
  assign enc_bit = fbits[idx_ff];

  // Next frame loads as the last bit leaves; idle if nothing waits
  always_comb begin
    nxt_cur = cur_ff;
    nxt_idx = idx_ff;
    nxt_pat = pat_ff;
    if (take) begin
      if (last) begin
        nxt_idx = 5'h00;
        nxt_cur = buf_out_valid ? buf_out : lsf_pkg::IDLE_FRAME;
        nxt_pat = {pat_ff[0], pat_ff[7:1]};
      end else begin
        nxt_idx = idx_ff + 5'h01;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cur_ff <= lsf_pkg::IDLE_FRAME;
      idx_ff <= 5'h00;
      pat_ff <= lsf_pkg::SYNC_PAT;
    end else begin
      cur_ff <= nxt_cur;
      idx_ff <= nxt_idx;
      pat_ff <= nxt_pat;
    end
  end

  // ****************************************
  // Line encoder and output disable
  // ****************************************
  logic enc_lvl;
  logic bias_ff, nxt_bias;

  lsf_line_enc u_enc (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_half_tick (i_half_cell_tick),
    .i_bit       (enc_bit),
    .o_take      (take),
    .o_line_lvl  (enc_lvl)
  );

  // Either the pin or the diagnostics bit holds the line at bias
  always_comb begin
    nxt_bias = flt_ff[P_DIS] | cfg.line_output_disable_bit;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bias_ff <= 1'h1;
    end else begin
      bias_ff <= nxt_bias;
    end
  end

  assign o_line_bias = bias_ff;
  assign o_line_tx   = enc_lvl & ~bias_ff;

endmodule

// [src/lsf_line_enc.sv]
// Differential and biphase line encoder
`timescale 1ns/1ps
module lsf_line_enc (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Half-cell timing and data
  input  wire logic i_half_tick,
  input  wire logic i_bit,
  output logic      o_take,
  // Line level
  output logic      o_line_lvl
);

  logic phase_ff, nxt_phase;
  logic diff_ff, nxt_diff;
  logic lvl_ff, nxt_lvl;

  // A bit is taken at the start of each cell
  assign o_take     = i_half_tick & ~phase_ff;
  assign o_line_lvl = lvl_ff;

  // First half is the inverse, second half the code bit
  always_comb begin
    nxt_phase = phase_ff;
    nxt_diff  = diff_ff;
    nxt_lvl   = lvl_ff;
    if (i_half_tick) begin
      nxt_phase = ~phase_ff;
      if (!phase_ff) begin
        nxt_diff = i_bit ^ diff_ff;
        nxt_lvl  = ~(i_bit ^ diff_ff);
      end else begin
        nxt_lvl = diff_ff;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      phase_ff <= 1'h0;
      diff_ff  <= 1'h0;
      lvl_ff   <= 1'h0;
    end else begin
      phase_ff <= nxt_phase;
      diff_ff  <= nxt_diff;
      lvl_ff   <= nxt_lvl;
    end
  end

endmodule

// [src/lsf_pkg.sv]
// Shared constants and carriers of the subscriber line framer
package lsf_pkg;

  // ****************************************
  // Control byte fields
  // ****************************************
  localparam int        CTRL_DIAG_KEEP = 2;  // 0 clears diagnostics at frame pulse
  localparam int        CTRL_DCHAN_IN_BCHAN_SELECT      = 3;  // dchan_in_bchan_select
  localparam int        CTRL_RATE160   = 4;  // 1 selects 160 kbit/s
  localparam int        CTRL_MODEM     = 5;  // modem_mode
  localparam int        CTRL_MASTER    = 6;  // master_role, else slave_role
  localparam int        CTRL_HK        = 7;  // housekeeping_bit to send
  localparam logic [7:0] CTRL_RST      = 8'h00;

  // ****************************************
  // Diagnostics byte fields
  // ****************************************
  localparam int        DIAG_LOOP_LO   = 2;
  localparam int        DIAG_LOOP_HI   = 3;
  localparam int        DIAG_DEF_SEL   = 3;  // picks default mode 1 or 2
  localparam int        DIAG_DEF_LO    = 4;
  localparam int        DIAG_DEF_HI    = 7;
  localparam int        DIAG_DLO       = 6;  // line_output_disable_bit
  localparam logic [7:0] DIAG_RST      = 8'h00;
  localparam logic [3:0] DIAG_DEF_KEY  = 4'hf;
  localparam logic [1:0] LOOP_LINE     = 2'h1;  // {bit3,bit2}
  localparam logic [1:0] LOOP_STREAM   = 2'h2;

  // ****************************************
  // Status word and framing
  // ****************************************
  localparam logic [2:0] STAT_RSVD     = 3'h7;
  localparam logic       REV_ID        = 1'h1;  // Arbitrary revision value
  localparam logic [4:0] LEN_MODEM     = 5'h08;
  localparam logic [4:0] LEN_80        = 5'h0a;
  localparam logic [4:0] LEN_160       = 5'h14;
  localparam logic [7:0] SYNC_PAT      = 8'hb8;  // Sync bit pattern, bit 0 first
  localparam logic [5:0] D_PAD         = 6'h3f;

  // Frame content offered by the system
  typedef struct packed {
    logic       hk;
    logic [1:0] dch;
    logic [7:0] b2;
    logic [7:0] b1;
  } lsf_frame_t;

  localparam lsf_frame_t IDLE_FRAME = 19'h7ffff;

  // Effective line configuration
  typedef struct packed {
    logic       modem;
    logic       rate160;
    logic       dchan_in_bchan_select;
    logic       hk;
    logic       line_output_disable_bit;
    logic [1:0] loop;
  } lsf_cfg_t;

endpackage
